// File: mrs_reset_seq.sv
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns

// How it works
// - internal reset from first high sample, repeated while high
// - strobe pins are inputs during reset
// - fetch starts at address zero
// - reset loads all port latches with ones
// - port 2 follows external program select
// - reset leaves internal ram untouched
// - hardware reset hits only usb interface
// - soft reset bit cleared by hardware
// - clearing soft bit raises endpoint init request
// - rc faster means failure, rc clocks chip
// - main clock once seen, then hold 768 rc cycles
// - no execution while reset pin high
// - watchdog flag set at power-up, external clears
// - sample reset once, at state 5 phase 2
// - reset procedure takes two machine cycles
// - address at s5p1, latch fall s5p2
module mrs_reset_seq #(
  parameter int HOLD_CYC = mrs_pkg::WD_HOLD  // rc cycles held after oscillator starts
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,     // power-on reset of the model
  input  wire mrs_pkg::mrs_axi_req_t axi_req,
  output mrs_pkg::mrs_axi_rsp_t      axi_rsp,
  input  wire logic                  reset_in,    // external reset pin, active high
  input  wire logic                  ext_program_select,
  input  wire logic                  rc_faster,   // rc clock outruns main oscillator
  input  wire logic                  usb_core_done,  // usb soft reset finished, pulse
  input  wire logic                  ale_in,      // latch strobe pin input
  input  wire logic                  prog_fetch_strobe_in,
  output logic                       ale_out,
  output logic                       ale_oe,
  output logic                       prog_fetch_strobe_out,
  output logic                       prog_fetch_strobe_oe,
  output logic [15:0]                fetch_addr,  // program address on the bus
  output logic                       addr_valid,  // address output active
  output logic [7:0]                 port0_out,
  output logic [7:0]                 port0_oe,    // open drain: enable pulls low
  output logic [7:0]                 port1_out,
  output logic [7:0]                 port2_out,
  output logic [7:0]                 port3_out,
  output logic                       cpu_reset,   // core held in reset
  output logic                       usb_if_reset,    // usb cpu interface and mmu
  output logic                       usb_core_reset,  // usb core itself
  output logic                       clk_sel_rc,  // chip clock from rc oscillator
  output logic                       power_down
);
  import mrs_pkg::*;

  // pin synchronisers, two flops each; only stage two is read
  logic [2:0] sync_a;               // first stage
  logic [2:0] sync_b;               // second stage
  wire        rst_pin  = sync_b[0];
  wire        eps_pin  = sync_b[1];
  wire        osc_fail = sync_b[2];

  // timing state
  logic [3:0]  phase;               // 0..11 within the machine cycle
  logic [1:0]  hi_samples;          // consecutive high samples, saturating
  logic        in_reset;            // internal reset procedure active
  logic        running;             // program execution started
  logic        run_pend;            // release seen, waiting for s5p1

  // watchdog
  mrs_wd_t     wd_state;
  logic [9:0]  wd_cnt;              // hold counter
  logic        wd_flag;             // osc_watchdog_status

  // registers
  logic        soft_bit;
  logic        ep_init;             // endpoint_init_request
  logic        pd;
  logic [31:0] port_latch;          // four 8-bit latches

  // axi state
  logic              aw_have;
  logic              w_have;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              bvalid;
  logic [1:0]        bresp;
  logic              rvalid;
  logic [31:0]       rdata;
  logic [1:0]        rresp;

  // ------------------------------------------------------------
  // decoding
  // ------------------------------------------------------------
  wire ph_s5p2   = (phase == S5P2);
  wire ph_s5p1   = (phase == S5P1);
  wire wd_req    = (wd_state != WD_RUN);                     // watchdog reset request
  wire hold      = in_reset | wd_req;
  wire rst_start = ph_s5p2 & rst_pin;
  wire rst_rel   = ph_s5p2 & ~rst_pin;

  // hold counter limit, cut to counter width on purpose
  wire [9:0] wd_last = 10'(HOLD_CYC - 1);

  // write channel decode
  wire do_write  = aw_have & w_have & ~bvalid;
  wire wr_ctrl   = do_write & (aw_addr == CTRL_OFF);
  wire wr_status = do_write & (aw_addr == STATUS_OFF);
  wire wr_port   = do_write & (aw_addr == PORT_OFF);
  wire wr_ok     = wr_ctrl | wr_status | wr_port;

  // software requests, lane 0 only for the flag registers
  wire soft_set  = wr_ctrl & w_strb[0] & w_data[CTRL_SOFT_BIT];
  wire pd_set    = wr_ctrl & w_strb[0] & w_data[CTRL_PD_BIT];
  wire init_clr  = wr_status & w_strb[0] & w_data[ST_EPINIT_BIT];

  // usb core done only counts while a soft reset is pending
  wire soft_done = soft_bit & usb_core_done;

  // read decode
  wire do_read   = axi_req.arvalid & ~rvalid;
  wire [31:0] status_word = {26'h0, pd, clk_sel_rc, hold, soft_bit, ep_init, wd_flag};
  wire [31:0] ctrl_word   = {30'h0, pd, soft_bit};
  wire rd_ctrl   = (axi_req.araddr == CTRL_OFF);
  wire rd_status = (axi_req.araddr == STATUS_OFF);
  wire rd_port   = (axi_req.araddr == PORT_OFF);
  wire rd_ok     = rd_ctrl | rd_status | rd_port;
  wire [31:0] rd_word = rd_ctrl   ? ctrl_word :
                        rd_status ? status_word :
                        rd_port   ? port_latch : 32'h0;

  // byte lane merge for the port latches
  logic [31:0] port_wr;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign port_wr[g*8 +: 8] = w_strb[g] ? w_data[g*8 +: 8] : port_latch[g*8 +: 8];
    end
  endgenerate

  // latch strobe shape: high one phase, after s2p1 and after s5p1, so it falls at s5p2 late
  // in the machine cycle; the first fall after release lands on s5p2
  wire ale_win   = (phase == S5P1) | (phase == S2P1);
  wire next_run  = running | (run_pend & ph_s5p1);

  // ------------------------------------------------------------
  // synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    sync_a <= {rc_faster, ext_program_select, reset_in};
    sync_b <= sync_a;
  end

  // ------------------------------------------------------------
  // phase and state counter of the machine cycle
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase <= 4'h0;
    end else if (phase == PH_LAST) begin
      phase <= 4'h0;
    end else begin
      phase <= phase + 4'h1;
    end
  end

  // ------------------------------------------------------------
  // reset sampling: one look per machine cycle, the procedure
  // loads defaults from the first high sample on and repeats each cycle
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hi_samples <= 2'h0;
      in_reset   <= 1'b1;
    end else if (rst_start) begin
      // a single high sample starts the procedure; it completes two
      // machine cycles later, so a one-cycle glitch still resets fully
      hi_samples <= (hi_samples == 2'h3) ? 2'h3 : hi_samples + 2'h1;
      in_reset   <= 1'b1;
    end else if (rst_rel && hi_samples != 2'h1) begin
      hi_samples <= 2'h0;
      in_reset   <= 1'b0;
    end else if (rst_rel) begin
      // released after only one sample: finish the second cycle first
      hi_samples <= 2'h2;
    end
  end

  // ------------------------------------------------------------
  // release sequencing toward the first fetch
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || hold) begin
      run_pend <= 1'b0;
      running  <= 1'b0;
    end else begin
      run_pend <= run_pend | ~running;
      running  <= next_run;
    end
  end

  // ------------------------------------------------------------
  // oscillator watchdog: rc clock feeds the chip until the main
  // oscillator is seen, then the core stays held for the hold time;
  // one aclk edge here stands for one rc clock period
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wd_state <= WD_FAIL;
      wd_cnt   <= 10'h0;
    end else begin
      case (wd_state)
        WD_FAIL: begin
          wd_cnt <= 10'h0;
          if (!osc_fail) begin
            wd_state <= WD_HOLDING;
          end
        end
        WD_HOLDING: begin
          if (osc_fail) begin
            wd_state <= WD_FAIL;
          end else if (wd_cnt == wd_last) begin
            wd_state <= WD_RUN;
          end else begin
            wd_cnt <= wd_cnt + 10'h1;
          end
        end
        WD_RUN: begin
          if (osc_fail) begin
            wd_state <= WD_FAIL;
          end
        end
        default: begin
          wd_state <= WD_FAIL;
        end
      endcase
    end
  end

  // watchdog flag: power-up and failure set it, only the external
  // reset procedure clears it; a set in the same cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wd_flag <= 1'b1;
    end else if (wd_state == WD_FAIL) begin
      wd_flag <= 1'b1;
    end else if (in_reset) begin
      wd_flag <= 1'b0;
    end
  end

  // power-down: ended only by the external reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pd <= 1'b0;
    end else if (in_reset) begin
      pd <= 1'b0;
    end else if (pd_set) begin
      pd <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // usb soft reset handshake; hardware reset clears only the
  // interface copy of these flags, never the usb core
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || hold) begin
      soft_bit <= 1'b0;
      ep_init  <= 1'b0;
    end else begin
      if (soft_done) begin
        soft_bit <= 1'b0;
      end else if (soft_set) begin
        soft_bit <= 1'b1;
      end
      if (soft_done) begin
        ep_init <= 1'b1;
      end else if (init_clr) begin
        ep_init <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // port latches and program address; no ram is touched here so
  // internal memory keeps its contents across reset
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || hold) begin
      port_latch <= PORT_RST;
    end else if (wr_port) begin
      port_latch <= port_wr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || hold) begin
      fetch_addr <= PC_RST;
    end else if (running && ph_s5p2) begin
      fetch_addr <= fetch_addr + 16'h1;                      // next byte once per machine cycle, at s5p2
    end
  end

  // latch strobe and fetch strobe, registered
  always_ff @(posedge aclk) begin
    if (!aresetn || hold) begin
      ale_out               <= 1'b0;
      prog_fetch_strobe_out <= 1'b1;
      addr_valid            <= 1'b0;
    end else begin
      ale_out               <= next_run & ale_win;
      prog_fetch_strobe_out <= ~(running & ~eps_pin & ~ale_win);
      addr_valid            <= next_run;
    end
  end

  // strobe pins float during reset; inputs ignored, never acted on
  assign ale_oe               = ~hold;
  assign prog_fetch_strobe_oe = ~hold;

  // port pins: port 0 open drain, zero bits pull low
  assign port0_out = 8'h00;
  assign port0_oe  = ~port_latch[7:0];
  assign port1_out = port_latch[15:8];
  assign port3_out = port_latch[31:24];
  // with external program the lines carry the address high byte
  assign port2_out = eps_pin ? port_latch[23:16] : fetch_addr[15:8];

  assign cpu_reset      = hold;
  assign usb_if_reset   = hold;
  assign usb_core_reset = soft_bit;
  assign clk_sel_rc     = (wd_state == WD_FAIL);
  assign power_down     = pd;

  // ------------------------------------------------------------
  // axi4-lite slave: address and data taken in either order,
  // one write and one read at a time
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have <= 1'b0;
      w_have  <= 1'b0;
      aw_addr <= '0;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
    end else if (do_write) begin
      aw_have <= 1'b0;
      w_have  <= 1'b0;
    end else begin
      if (axi_req.awvalid && axi_rsp.awready) begin
        aw_have <= 1'b1;
        aw_addr <= axi_req.awaddr;
      end
      if (axi_req.wvalid && axi_rsp.wready) begin
        w_have <= 1'b1;
        w_data <= axi_req.wdata;
        w_strb <= axi_req.wstrb;
      end
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OK;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp  <= wr_ok ? RESP_OK : RESP_ERR;                  // unmapped: slverr
    end else if (axi_req.bready) begin
      bvalid <= 1'b0;
    end
  end

  // read response, data captured in the accept cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0;
      rresp  <= RESP_OK;
    end else if (do_read) begin
      rvalid <= 1'b1;
      rdata  <= rd_word;
      rresp  <= rd_ok ? RESP_OK : RESP_ERR;
    end else if (axi_req.rready) begin
      rvalid <= 1'b0;
    end
  end

  // handshake outputs
  assign axi_rsp.awready = ~aw_have & ~bvalid;
  assign axi_rsp.wready  = ~w_have & ~bvalid;
  assign axi_rsp.bvalid  = bvalid;
  assign axi_rsp.bresp   = bresp;
  assign axi_rsp.arready = ~rvalid;
  assign axi_rsp.rvalid  = rvalid;
  assign axi_rsp.rdata   = rdata;
  assign axi_rsp.rresp   = rresp;

endmodule : mrs_reset_seq

// File: mrs_pkg.sv
package mrs_pkg;

  // register byte offsets on the axi4-lite bus
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] PORT_OFF   = 8'h08;
  localparam int         ADDR_W     = 8;

  // control register fields
  localparam int CTRL_SOFT_BIT = 0;  // usb_soft_reset_bit, write one to start
  localparam int CTRL_PD_BIT   = 1;  // software power-down request

  // status register fields
  localparam int ST_WDFLAG_BIT = 0;  // osc_watchdog_status
  localparam int ST_EPINIT_BIT = 1;  // endpoint_init_request, write one clears
  localparam int ST_SOFT_BIT  = 2;   // usb_soft_reset_bit mirror
  localparam int ST_HOLD_BIT  = 3;   // cpu held in reset
  localparam int ST_RC_BIT    = 4;   // chip clocked from rc clock
  localparam int ST_PD_BIT    = 5;   // power-down active

  // machine cycle: six states of two phases, one phase per clock
  localparam int          PHASES   = 12;
  localparam logic [3:0]  PH_LAST  = 4'hb;
  localparam logic [3:0]  S5P1     = 4'h8;  // state 5 phase 1
  localparam logic [3:0]  S5P2     = 4'h9;  // state 5 phase 2
  localparam logic [3:0]  S2P1     = 4'h2;  // second latch strobe rises

  // reset values
  localparam logic [31:0] PORT_RST = 32'hffff_ffff;  // all four latches ones
  localparam logic [15:0] PC_RST   = 16'h0000;       // first fetch address
  localparam int          WD_HOLD  = 768;            // rc cycles of hold

  // axi4-lite responses
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  // watchdog states
  typedef enum logic [1:0] {WD_FAIL, WD_HOLDING, WD_RUN} mrs_wd_t;

  // bus master to slave
  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic              awvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              bready;
    logic [ADDR_W-1:0] araddr;
    logic              arvalid;
    logic              rready;
  } mrs_axi_req_t;

  // bus slave to master
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } mrs_axi_rsp_t;

endpackage : mrs_pkg

// File: mrs_reset_driver.sv
`timescale 1ns/1ns
// external supervisor: one trigger gives one clean high pulse on the pin
module mrs_reset_driver #(
  parameter int MIN_CYC = 12  // one machine cycle of twelve phases
) (
  input  wire logic        aclk,
  input  wire logic        trig,      // start a pulse
  input  wire logic [15:0] len,       // requested pulse length in clocks
  output logic             reset_in   // active high reset pin
);
  import mrs_pkg::*;
  logic [15:0] cnt = 16'h0;  // clocks of pulse still to go
  // short requests are stretched, so the pin never sees a runt pulse
  always @(posedge aclk) begin
    if (trig)
      cnt <= (len < MIN_CYC) ? 16'(MIN_CYC) : len;
    else if (cnt != 16'h0)
      cnt <= cnt - 16'h1;
  end
  assign reset_in = (cnt != 16'h0);
endmodule : mrs_reset_driver

// File: mrs_reset_seq_assertions.sv
`timescale 1ns/1ns
// pin-level checks; long waits are counted in helper counters
module mrs_reset_seq_assertions #(
  parameter int HOLD_CYC = 768  // watchdog hold in clocks
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        reset_in,
  input wire logic        ext_program_select,
  input wire logic        rc_faster,
  input wire logic        usb_core_done,
  input wire logic        ale_out,
  input wire logic        ale_oe,
  input wire logic        prog_fetch_strobe_oe,
  input wire logic [15:0] fetch_addr,
  input wire logic [7:0]  port0_oe,
  input wire logic [7:0]  port1_out,
  input wire logic [7:0]  port2_out,
  input wire logic [7:0]  port3_out,
  input wire logic        cpu_reset,
  input wire logic        usb_if_reset,
  input wire logic        usb_core_reset,
  input wire logic        clk_sel_rc,
  input wire logic        power_down
);
  import mrs_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [4:0]  pin_cnt;  // run of high pin samples
  logic [15:0] wd_cnt;   // clocks since the rc clock stopped winning
  // saturates so a long reset never wraps into a short one
  always_ff @(posedge aclk) begin
    if (!aresetn || !reset_in) pin_cnt <= 5'h0;
    else if (pin_cnt != 5'h1f) pin_cnt <= pin_cnt + 5'h1;
  end
  // starts saturated: nothing is claimed until the rc clock has won once
  always_ff @(posedge aclk) begin
    if (!aresetn) wd_cnt <= 16'hffff;
    else if (rc_faster) wd_cnt <= 16'h0;
    else if (wd_cnt != 16'hffff) wd_cnt <= wd_cnt + 16'h1;
  end
  AST_STROBE_IN:
    assert property (cpu_reset |-> !ale_oe && !prog_fetch_strobe_oe) else $error("strobe driven in reset");
  AST_PORTS_ONES:
    assert property (cpu_reset [*2] |-> {port3_out, port1_out, port0_oe} == 24'hffff00 && fetch_addr == PC_RST)
    else $error("port or fetch state wrong in reset");
  AST_PORT2_SEL:
    assert property ((cpu_reset && $stable(ext_program_select)) [*4] |-> port2_out == {8{ext_program_select}})
    else $error("port 2 ignores program select");
  AST_PIN_HOLDS:
    assert property (pin_cnt >= 5'h10 |-> cpu_reset) else $error("core runs with pin high");
  AST_SAMPLE_EDGE:
    assert property ($rose(cpu_reset) && !$past(power_down) |-> $past(ale_out)) else $error("pin sampled off phase");
  AST_MIN_RESET:
    assert property ($rose(cpu_reset) |-> cpu_reset [*8] ##1 cpu_reset [*4]) else $error("reset too short");
  AST_FIRST_LATCH:
    assert property ($fell(cpu_reset) |-> ##[0:12] ale_out) else $error("no latch strobe after release");
  AST_USB_SPLIT:
    assert property (cpu_reset |-> usb_if_reset && !$rose(usb_core_reset)) else $error("usb reset split wrong");
  AST_SOFT_DONE:
    assert property (usb_core_reset && usb_core_done |=> !usb_core_reset) else $error("soft reset not ended");
  AST_RC_SELECT:
    assert property (rc_faster [*5] |-> clk_sel_rc && cpu_reset) else $error("rc clock not selected");
  AST_WD_HOLD:
    assert property (wd_cnt < HOLD_CYC |-> cpu_reset) else $error("watchdog hold too short");
  cover property ($fell(cpu_reset));
  cover property ($fell(usb_core_reset));
  cover property (wd_cnt == HOLD_CYC);
endmodule : mrs_reset_seq_assertions

bind mrs_reset_seq mrs_reset_seq_assertions #(.HOLD_CYC(HOLD_CYC)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .reset_in(reset_in), .ext_program_select(ext_program_select),
  .rc_faster(rc_faster), .usb_core_done(usb_core_done), .ale_out(ale_out), .ale_oe(ale_oe),
  .prog_fetch_strobe_oe(prog_fetch_strobe_oe), .fetch_addr(fetch_addr), .port0_oe(port0_oe),
  .port1_out(port1_out), .port2_out(port2_out), .port3_out(port3_out), .cpu_reset(cpu_reset),
  .usb_if_reset(usb_if_reset), .usb_core_reset(usb_core_reset), .clk_sel_rc(clk_sel_rc),
  .power_down(power_down));

// File: mrs_reset_seq_tb.sv
`timescale 1ns/1ns
module mrs_reset_seq_tb;
  import mrs_pkg::*;
  localparam int HOLD_T = 8;  // short hold keeps the run brief
  typedef struct packed {
    logic        we;
    logic [7:0]  addr;
    logic [31:0] data;
    logic [1:0]  resp;
    logic [31:0] rdata;
  } mrs_row_t;
  logic aclk, aresetn, trig, eps, rc_faster, usb_core_done, reset_in;
  logic ale_out, ale_oe, pfs_out, pfs_oe, addr_valid, cpu_reset;
  logic usb_if_reset, usb_core_reset, clk_sel_rc, power_down;
  logic [15:0] len, fetch_addr;
  logic [7:0]  port0_out, port0_oe, port1_out, port2_out, port3_out;
  mrs_axi_req_t req;
  mrs_axi_rsp_t rsp;
  logic [31:0] d;
  logic [1:0]  r;
  int          num_errors, n_compared, cyc, k;
  // bus cases: reset value, write and read back, unmapped, read-only status
  mrs_row_t rows [8] = '{
    '{1'b0, PORT_OFF, 32'h0, RESP_OK, PORT_RST},
    '{1'b1, PORT_OFF, 32'h0fa5_3c81, RESP_OK, 32'h0},
    '{1'b0, PORT_OFF, 32'h0, RESP_OK, 32'h0fa5_3c81},
    '{1'b0, 8'h0c, 32'h0, RESP_ERR, 32'h0},
    '{1'b1, 8'h40, 32'h1, RESP_ERR, 32'h0},
    '{1'b0, STATUS_OFF, 32'h0, RESP_OK, 32'h0},
    '{1'b1, STATUS_OFF, 32'h3d, RESP_OK, 32'h0},
    '{1'b0, STATUS_OFF, 32'h0, RESP_OK, 32'h0}};

  // strobe pins are left alone by the outside
  mrs_reset_seq #(.HOLD_CYC(HOLD_T)) dut (
    .aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp), .reset_in(reset_in),
    .ext_program_select(eps), .rc_faster(rc_faster), .usb_core_done(usb_core_done),
    .ale_in(1'b0), .prog_fetch_strobe_in(1'b0), .ale_out(ale_out), .ale_oe(ale_oe),
    .prog_fetch_strobe_out(pfs_out), .prog_fetch_strobe_oe(pfs_oe), .fetch_addr(fetch_addr),
    .addr_valid(addr_valid), .port0_out(port0_out), .port0_oe(port0_oe), .port1_out(port1_out),
    .port2_out(port2_out), .port3_out(port3_out), .cpu_reset(cpu_reset),
    .usb_if_reset(usb_if_reset), .usb_core_reset(usb_core_reset), .clk_sel_rc(clk_sel_rc),
    .power_down(power_down));
  mrs_reset_driver u_drv (.aclk(aclk), .trig(trig), .len(len), .reset_in(reset_in));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // hang guard: the whole run needs well under a thousand clocks
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      end_sim();
    end
  end

  task automatic end_sim;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // samples at the falling edge, where everything has settled
  task automatic cycles(input int n);
    repeat (n) @(negedge aclk);
  endtask : cycles
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic at, wt, b;
    @(posedge aclk);
    req.awaddr <= a;
    req.wdata <= v;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(negedge aclk);
      at = req.awvalid && rsp.awready;
      wt = req.wvalid && rsp.wready;
      b = rsp.bvalid;
      rs = rsp.bresp;
      @(posedge aclk);
      if (at) req.awvalid <= 1'b0;
      if (wt) req.wvalid <= 1'b0;
    end while (b !== 1'b1);
    req.bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic t, rv;
    @(posedge aclk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(negedge aclk);
      t = req.arvalid && rsp.arready;
      rv = rsp.rvalid;
      v = rsp.rdata;
      rs = rsp.rresp;
      @(posedge aclk);
      if (t) req.arvalid <= 1'b0;
    end while (rv !== 1'b1);
    req.rready <= 1'b0;
  endtask : rd
  // pin pulse; returns while the pin is still high and reset has landed
  task automatic pulse_rst(input logic [15:0] n);
    @(posedge aclk) begin
      trig <= 1'b1;
      len <= n;
    end
    @(posedge aclk) trig <= 1'b0;
    cycles(16);
  endtask : pulse_rst
  task automatic wait_run;
    while (reset_in !== 1'b0) @(negedge aclk);
    while (cpu_reset !== 1'b0) @(negedge aclk);
  endtask : wait_run

  initial begin
    req = '0;
    trig = 1'b1;
    len = 16'(HOLD_T + 80);
    eps = 1'b0;
    rc_faster = 1'b1;
    usb_core_done = 1'b0;
    aresetn = 1'b0;
    num_errors = 0;
    n_compared = 0;
    cyc = 0;
    @(posedge aclk) trig <= 1'b0;
    repeat (11) @(posedge aclk);
    aresetn <= 1'b1;
    // power-up: rc clock wins first, the pin outlasts the hold
    cycles(20);
    chk("rc clock select", 1, clk_sel_rc);
    @(posedge aclk) rc_faster <= 1'b0;
    cycles(HOLD_T + 20);
    chk("held by pin", 1, cpu_reset);
    while (reset_in !== 1'b0) @(negedge aclk);
    k = 0;
    while (ale_out !== 1'b1) begin
      @(negedge aclk);
      k++;
    end
    chk("release to latch", 1, 32'(k >= 11 && k <= 27));
    chk("first fetch", 32'(PC_RST), fetch_addr);
    chk("address out", 1, addr_valid);
    chk("port0 level", 32'h0, port0_out);
    cycles(1);
    chk("fetch strobe", 0, pfs_out);
    foreach (rows[i]) begin
      if (rows[i].we) wr(rows[i].addr, rows[i].data, r);
      else rd(rows[i].addr, d, r);
      chk("bus response", 32'(rows[i].resp), 32'(r));
      if (!rows[i].we) chk("read data", rows[i].rdata, d);
    end
    // latches written, then a pin reset must load ones again
    chk("ports written", 32'h0f3c7e, {port3_out, port1_out, port0_oe});
    pulse_rst(16'h1e);
    chk("port2 select low", 32'h0, port2_out);
    chk("strobe enables", 32'h0, {ale_oe, pfs_oe});
    chk("usb split", 32'h2, {usb_if_reset, usb_core_reset});
    wait_run();
    chk("ports reloaded", 32'hffff00, {port3_out, port1_out, port0_oe});
    @(posedge aclk) eps <= 1'b1;
    pulse_rst(16'h1e);
    chk("port2 select high", 32'hff, port2_out);
    wait_run();
    // usb soft reset, then the init request it leaves behind
    wr(CTRL_OFF, 32'h1, r);
    rd(STATUS_OFF, d, r);
    chk("soft bit set", 32'h4, d);
    chk("core reset", 1, usb_core_reset);
    @(posedge aclk) usb_core_done <= 1'b1;
    @(posedge aclk) usb_core_done <= 1'b0;
    rd(STATUS_OFF, d, r);
    chk("init request", 32'h2, d);
    wr(STATUS_OFF, 32'h2, r);
    rd(STATUS_OFF, d, r);
    chk("init cleared", 32'h0, d);
    // power-down ends only by a pin reset
    wr(CTRL_OFF, 32'h2, r);
    rd(STATUS_OFF, d, r);
    chk("power down", 32'h20, d);
    pulse_rst(16'h1e);
    wait_run();
    rd(STATUS_OFF, d, r);
    chk("power down ended", 32'h0, d);
    // second power-up with no pin reset: hold length and the sticky flag
    @(posedge aclk) begin
      aresetn <= 1'b0;
      rc_faster <= 1'b1;
    end
    cycles(12);
    @(posedge aclk) aresetn <= 1'b1;
    cycles(20);
    @(posedge aclk) rc_faster <= 1'b0;
    k = 0;
    while (cpu_reset !== 1'b0) begin
      @(negedge aclk);
      k++;
    end
    chk("watchdog hold", 1, 32'(k >= HOLD_T && k <= HOLD_T + 30));
    rd(STATUS_OFF, d, r);
    chk("flag kept", 32'h1, d);
    pulse_rst(16'h1e);
    wait_run();
    rd(STATUS_OFF, d, r);
    chk("flag cleared", 32'h0, d);
    end_sim();
  end
endmodule : mrs_reset_seq_tb
